// ### rtl/uaf_pkg.sv
/*
  Package of the serial address filter: register map, field positions,
  reset values, bus states and the carrier types shared by the design.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
`default_nettype none

package uaf_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] UAF_IDX_SERIAL_CONTROL = 10'h098;
  localparam logic [9:0] UAF_IDX_OWN_ADDRESS = 10'h0a9;
  localparam logic [9:0] UAF_IDX_ADDRESS_MASK = 10'h0b9;
  localparam logic [9:0] UAF_IDX_FILTER_CTRL = 10'h0c0;
  localparam logic [9:0] UAF_IDX_INT_STATUS = 10'h0c1;
  localparam logic [9:0] UAF_IDX_INT_ENABLE = 10'h0c2;
  localparam logic [9:0] UAF_IDX_INT_CLEAR = 10'h0c3;

  localparam int UAF_ADDR_W = 12;
  localparam logic [11:0] UAF_ADDR_SERIAL_CONTROL = {UAF_IDX_SERIAL_CONTROL, 2'b00};
  localparam logic [11:0] UAF_ADDR_OWN_ADDRESS = {UAF_IDX_OWN_ADDRESS, 2'b00};
  localparam logic [11:0] UAF_ADDR_ADDRESS_MASK = {UAF_IDX_ADDRESS_MASK, 2'b00};
  localparam logic [11:0] UAF_ADDR_FILTER_CTRL = {UAF_IDX_FILTER_CTRL, 2'b00};
  localparam logic [11:0] UAF_ADDR_INT_STATUS = {UAF_IDX_INT_STATUS, 2'b00};
  localparam logic [11:0] UAF_ADDR_INT_ENABLE = {UAF_IDX_INT_ENABLE, 2'b00};
  localparam logic [11:0] UAF_ADDR_INT_CLEAR = {UAF_IDX_INT_CLEAR, 2'b00};

  // Serial control fields
  localparam int UAF_SC_BIT7_SHARED = 7;
  localparam int UAF_SC_MODE_BIT1 = 6;
  localparam int UAF_SC_MULTIPROC_ENABLE = 5;
  localparam int UAF_SC_REN = 4;
  localparam int UAF_SC_TB8 = 3;
  localparam int UAF_SC_RB8 = 2;
  localparam int UAF_SC_TI = 1;
  localparam int UAF_SC_RX_DONE = 0;

  // Filter control fields
  localparam int UAF_FC_BIT7_SELECT = 0;
  localparam int UAF_FC_RX_BAUD_SOURCE = 1;
  localparam int UAF_FC_TX_BAUD_SOURCE = 2;
  localparam int UAF_FC_W = 3;

  // Interrupt status, enable and clear fields
  localparam int UAF_INT_RX_DONE = 0;
  localparam int UAF_INT_FRAMING = 1;
  localparam int UAF_INT_W = 2;

  // Reset values
  localparam logic [7:0] UAF_SERIAL_CONTROL_RST = 8'h00;
  localparam logic [7:0] UAF_OWN_ADDRESS_RST = 8'h00;
  localparam logic [7:0] UAF_ADDRESS_MASK_RST = 8'h00;
  localparam logic [2:0] UAF_FILTER_CTRL_RST = 3'h0;
  localparam logic [1:0] UAF_INT_ENABLE_RST = 2'h0;

  // Bus slave states, Gray along idle, wait, done
  typedef enum logic [1:0] {
    UAF_BUS_IDLE = 2'b00,
    UAF_BUS_WAIT = 2'b01,
    UAF_BUS_DONE = 2'b11
  } uaf_bus_state_type;

  // One received frame from the receive shifter
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic bit9;
    logic stop_ok;
  } uaf_rx_frame_type;

  // Baud sources from the timers
  typedef struct packed {
    logic timer1_ovf;
    logic timer2_ovf;
  } uaf_baud_src_type;

endpackage

`default_nettype wire

// ### rtl/uaf_mask_cmp.sv
/*
  Masked byte comparator: hit when every cared-for bit of the value
  equals the reference. Pure combinational, no clock.
*/
`timescale 1ns/1ns
`default_nettype none

module uaf_mask_cmp #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] ref_value,
  input wire logic [WIDTH-1:0] care,
  output logic hit
);

  // A zero care bit matches anything
  assign hit = ~|((value ^ ref_value) & care);

endmodule // uaf_mask_cmp

`default_nettype wire

// ### rtl/uaf_sticky.sv
/*
  Bank of sticky flags: a set pulse raises a flag, a clear pulse drops it.
  Asynchronous active-low reset, one clock.
*/
`timescale 1ns/1ns
`default_nettype none

module uaf_sticky #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] flag
);

  logic [WIDTH-1:0] flag_reg;
  logic [WIDTH-1:0] flag_next;

  // Set wins, so an event in the clearing cycle is kept
  assign flag_next = (flag_reg & ~clr) | set;
  assign flag = flag_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

endmodule // uaf_sticky

`default_nettype wire

// ### rtl/uaf_filter.sv
/*
  Serial port receive address filter with framing-error flag and baud
  source selection, reached over AHB-Lite. Assumes a receive shifter that
  presents each finished frame for one cycle, and timers that give
  one-cycle overflow pulses, all synchronous to CORE_CLK.
*/
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module uaf_filter (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire uaf_pkg::uaf_rx_frame_type RX_FRAME,
  input wire uaf_pkg::uaf_baud_src_type BAUD_SRC,
  output logic TX_BAUD_TICK,
  output logic RX_BAUD_TICK,
  output logic [1:0] SERIAL_MODE,
  output logic RECEIVE_ENABLE,
  output logic IRQ
);

  // Bus slave state
  uaf_pkg::uaf_bus_state_type state_reg;
  uaf_pkg::uaf_bus_state_type state_next;
  logic [11:0] addr_reg;
  logic write_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;

  // Registers
  logic serial_mode_bit0_reg;
  logic framing_error_reg;
  logic [6:0] serial_low_reg;
  logic [7:0] own_address_reg;
  logic [7:0] address_mask_reg;
  logic [2:0] filter_ctrl_reg;
  logic [1:0] int_enable_reg;

  // Output flops
  logic tx_baud_reg;
  logic rx_baud_reg;
  logic irq_reg;

  // Bus decode
  logic take;
  logic access;
  logic do_write;
  logic wr_serial_control;
  logic wr_own_address;
  logic wr_address_mask;
  logic wr_filter_ctrl;
  logic wr_int_enable;
  logic wr_int_clear;
  logic sel_serial_control;
  logic sel_own_address;
  logic sel_address_mask;
  logic sel_filter_ctrl;
  logic sel_int_status;
  logic sel_int_enable;
  logic [7:0] wdata;
  logic [7:0] serial_control_view;
  logic [7:0] rd_byte;

  // Receive filter
  logic multiproc_enable;
  logic recv_enable;
  logic mode0;
  logic mode1;
  logic mode_13;
  logic bit7_select;
  logic filter_on;
  logic given_hit;
  logic broadcast_hit;
  logic addr_hit;
  logic [7:0] broadcast_address;
  logic frame_in;
  logic accept;
  logic rx_done_evt;
  logic framing_evt;
  logic marker_bit;

  // Next values
  logic serial_mode_bit0_next;
  logic framing_error_next;
  logic [6:0] serial_low_next;
  logic [6:0] serial_low_sw;
  logic [1:0] int_status;
  logic [1:0] int_set;
  logic [1:0] int_clr;

  // Bus decode: one wait state per transfer so reads never see stale data
  assign take = HSEL & HTRANS[1] & HREADY;
  assign access = (state_reg == uaf_pkg::UAF_BUS_WAIT);
  assign do_write = access & write_reg;
  assign wdata = HWDATA[7:0];
  assign sel_serial_control = (addr_reg == uaf_pkg::UAF_ADDR_SERIAL_CONTROL);
  assign sel_own_address = (addr_reg == uaf_pkg::UAF_ADDR_OWN_ADDRESS);
  assign sel_address_mask = (addr_reg == uaf_pkg::UAF_ADDR_ADDRESS_MASK);
  assign sel_filter_ctrl = (addr_reg == uaf_pkg::UAF_ADDR_FILTER_CTRL);
  assign sel_int_status = (addr_reg == uaf_pkg::UAF_ADDR_INT_STATUS);
  assign sel_int_enable = (addr_reg == uaf_pkg::UAF_ADDR_INT_ENABLE);
  assign wr_serial_control = do_write & sel_serial_control;
  assign wr_own_address = do_write & sel_own_address;
  assign wr_address_mask = do_write & sel_address_mask;
  assign wr_filter_ctrl = do_write & sel_filter_ctrl;
  assign wr_int_enable = do_write & sel_int_enable;
  assign wr_int_clear = do_write & (addr_reg == uaf_pkg::UAF_ADDR_INT_CLEAR);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      uaf_pkg::UAF_BUS_IDLE: begin
        if (take) begin
          state_next = uaf_pkg::UAF_BUS_WAIT;
        end
      end
      uaf_pkg::UAF_BUS_WAIT: begin
        state_next = uaf_pkg::UAF_BUS_DONE;
      end
      uaf_pkg::UAF_BUS_DONE: begin
        state_next = take ? uaf_pkg::UAF_BUS_WAIT : uaf_pkg::UAF_BUS_IDLE;
      end
      default: begin
        state_next = uaf_pkg::UAF_BUS_IDLE;
      end
    endcase
  end

  // Bit 7 shows the error flag or mode bit 0, by the select
  assign bit7_select = filter_ctrl_reg[uaf_pkg::UAF_FC_BIT7_SELECT];
  assign serial_control_view = {bit7_select ? framing_error_reg : serial_mode_bit0_reg,
                                serial_low_reg};

  // Unmapped and write-only addresses read as zero
  assign rd_byte = sel_serial_control ? serial_control_view :
                   sel_own_address ? own_address_reg :
                   sel_address_mask ? address_mask_reg :
                   sel_filter_ctrl ? {5'h00, filter_ctrl_reg} :
                   sel_int_status ? {6'h00, int_status} :
                   sel_int_enable ? {6'h00, int_enable_reg} : 8'h00;

  // Mode decode
  assign multiproc_enable = serial_low_reg[uaf_pkg::UAF_SC_MULTIPROC_ENABLE];
  assign recv_enable = serial_low_reg[uaf_pkg::UAF_SC_REN];
  assign mode0 = ~serial_mode_bit0_reg & ~serial_low_reg[uaf_pkg::UAF_SC_MODE_BIT1];
  assign mode1 = ~serial_mode_bit0_reg & serial_low_reg[uaf_pkg::UAF_SC_MODE_BIT1];
  assign mode_13 = serial_low_reg[uaf_pkg::UAF_SC_MODE_BIT1];

  // Shift-register mode never filters
  assign filter_on = multiproc_enable & ~mode0;

  // Broadcast: own address or mask, zeros are don't-care
  assign broadcast_address = own_address_reg | address_mask_reg;

  uaf_mask_cmp #(
    .WIDTH(8)
  ) u_given_cmp (
    .value(RX_FRAME.data),
    .ref_value(own_address_reg),
    .care(address_mask_reg),
    .hit(given_hit)
  );

  uaf_mask_cmp #(
    .WIDTH(8)
  ) u_broadcast_cmp (
    .value(RX_FRAME.data),
    .ref_value(broadcast_address),
    .care(broadcast_address),
    .hit(broadcast_hit)
  );

  assign addr_hit = given_hit | broadcast_hit;

  // Mode 1 takes the stop bit as marker; nine-bit modes the ninth bit
  assign marker_bit = mode1 ? RX_FRAME.stop_ok : RX_FRAME.bit9;
  assign frame_in = RX_FRAME.valid & recv_enable;
  assign accept = ~filter_on ? 1'b1 :
                  mode1 ? (addr_hit & RX_FRAME.stop_ok) :
                  (RX_FRAME.bit9 & addr_hit);
  assign rx_done_evt = frame_in & accept;
  assign framing_evt = frame_in & ~mode0 & ~RX_FRAME.stop_ok;

  // Software write first, hardware events override
  assign serial_low_sw = wr_serial_control ? wdata[6:0] : serial_low_reg;

  always_comb begin
    serial_low_next = serial_low_sw;
    if (rx_done_evt) begin
      serial_low_next[uaf_pkg::UAF_SC_RX_DONE] = 1'b1;
      if (!mode0) begin
        serial_low_next[uaf_pkg::UAF_SC_RB8] = marker_bit;
      end
    end
  end

  assign serial_mode_bit0_next = (wr_serial_control & ~bit7_select) ? wdata[7] :
                                 serial_mode_bit0_reg;

  // Valid stop bits never clear the flag; only software does
  assign framing_error_next = framing_evt |
                              ((wr_serial_control & bit7_select) ? wdata[7] :
                               framing_error_reg);

  // Interrupt status: set by events, cleared by writing ones
  assign int_set = {framing_evt, rx_done_evt};
  assign int_clr = wr_int_clear ? wdata[1:0] : 2'b00;

  uaf_sticky #(
    .WIDTH(uaf_pkg::UAF_INT_W)
  ) u_int_status (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .set(int_set),
    .clr(int_clr),
    .flag(int_status)
  );

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= uaf_pkg::UAF_BUS_IDLE;
      addr_reg <= 12'h000;
      write_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      hreadyout_reg <= (state_next != uaf_pkg::UAF_BUS_WAIT);
      if (take) begin
        addr_reg <= HADDR[11:0];
        write_reg <= HWRITE;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (access) begin
      hrdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      serial_mode_bit0_reg <= uaf_pkg::UAF_SERIAL_CONTROL_RST[7];
      framing_error_reg <= 1'b0;
      serial_low_reg <= uaf_pkg::UAF_SERIAL_CONTROL_RST[6:0];
    end else begin
      serial_mode_bit0_reg <= serial_mode_bit0_next;
      framing_error_reg <= framing_error_next;
      serial_low_reg <= serial_low_next;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      own_address_reg <= uaf_pkg::UAF_OWN_ADDRESS_RST;
      address_mask_reg <= uaf_pkg::UAF_ADDRESS_MASK_RST;
    end else begin
      if (wr_own_address) begin
        own_address_reg <= wdata;
      end
      if (wr_address_mask) begin
        address_mask_reg <= wdata;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      filter_ctrl_reg <= uaf_pkg::UAF_FILTER_CTRL_RST;
      int_enable_reg <= uaf_pkg::UAF_INT_ENABLE_RST;
    end else begin
      if (wr_filter_ctrl) begin
        filter_ctrl_reg <= wdata[2:0];
      end
      if (wr_int_enable) begin
        int_enable_reg <= wdata[1:0];
      end
    end
  end

  // Baud ticks pass one cycle late; zero outside modes 1 and 3
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_baud_reg <= 1'b0;
      rx_baud_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      tx_baud_reg <= mode_13 & (filter_ctrl_reg[uaf_pkg::UAF_FC_TX_BAUD_SOURCE] ?
                     BAUD_SRC.timer2_ovf : BAUD_SRC.timer1_ovf);
      rx_baud_reg <= mode_13 & (filter_ctrl_reg[uaf_pkg::UAF_FC_RX_BAUD_SOURCE] ?
                     BAUD_SRC.timer2_ovf : BAUD_SRC.timer1_ovf);
      irq_reg <= |(int_status & int_enable_reg);
    end
  end

  assign HRDATA = hrdata_reg;
  assign HREADYOUT = hreadyout_reg;
  // Every transfer answers OKAY
  assign HRESP = 1'b0;
  assign TX_BAUD_TICK = tx_baud_reg;
  assign RX_BAUD_TICK = rx_baud_reg;
  assign SERIAL_MODE = {serial_mode_bit0_reg, serial_low_reg[uaf_pkg::UAF_SC_MODE_BIT1]};
  assign RECEIVE_ENABLE = serial_low_reg[uaf_pkg::UAF_SC_REN];
  assign IRQ = irq_reg;

endmodule // uaf_filter

`default_nettype wire

// ### test/uaf_node_model.sv
/*
  Far side: the other nodes on the shared line, seen as finished frames.
  Assumes the bench asks for one frame at a time, synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none

module uaf_node_model (
  input wire logic clk,
  input wire logic send,
  input wire logic [9:0] word,
  output var uaf_pkg::uaf_rx_frame_type frame
);
  initial frame = '0;
  // Lines toggle between frames so no stale byte looks valid
  always @(posedge clk) begin
    frame.valid <= send;
    frame.data <= send ? word[7:0] : ~frame.data;
    frame.bit9 <= send ? word[9] : ~frame.bit9;
    frame.stop_ok <= send ? word[8] : ~frame.stop_ok;
  end
endmodule // uaf_node_model

`default_nettype wire

// ### test/uaf_filter_chk.sv
/*
  Port checker of the address filter.
  Assumes the one slave's HREADYOUT feeds HREADY; one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

module uaf_filter_chk (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire uaf_pkg::uaf_rx_frame_type RX_FRAME,
  input wire uaf_pkg::uaf_baud_src_type BAUD_SRC,
  input wire logic TX_BAUD_TICK,
  input wire logic RX_BAUD_TICK,
  input wire logic [1:0] SERIAL_MODE,
  input wire logic RECEIVE_ENABLE,
  input wire logic IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  wire logic take = HSEL && HTRANS[1] && HREADY;
  wire logic ovf = BAUD_SRC.timer1_ovf || BAUD_SRC.timer2_ovf;
  sequence s_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  chk_bus_wait: assert property (take |=> s_wait)
    else $error("transfer without one wait state");
  chk_ready_pulse: assert property (!HREADYOUT |=> HREADYOUT)
    else $error("wait state too long");
  chk_rdata_width: assert property (HRDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_rdata_hold: assert property (HREADYOUT && $past(HREADYOUT) |-> $stable(HRDATA))
    else $error("read data moved outside transfer");
  chk_tx_tick_src: assert property (TX_BAUD_TICK |-> $past(ovf) && $past(SERIAL_MODE[0]))
    else $error("transmit tick without cause");
  chk_rx_tick_src: assert property (RX_BAUD_TICK |-> $past(ovf) && $past(SERIAL_MODE[0]))
    else $error("receive tick without cause");
  chk_cfg_by_bus: assert property ($changed({SERIAL_MODE, RECEIVE_ENABLE}) |-> !$past(HREADYOUT))
    else $error("mode changed without a write");
  chk_irq_cause: assert property ($changed(IRQ) |-> $past(RX_FRAME.valid, 2) || !$past(HREADYOUT, 2))
    else $error("interrupt moved without cause");
endmodule // uaf_filter_chk

bind uaf_filter uaf_filter_chk chk_u (.CORE_CLK, .RSTN, .HSEL, .HTRANS, .HREADY, .HRDATA,
  .HREADYOUT, .RX_FRAME, .BAUD_SRC, .TX_BAUD_TICK, .RX_BAUD_TICK, .SERIAL_MODE,
  .RECEIVE_ENABLE, .IRQ);

`default_nettype wire

// ### test/uaf_filter_tb.sv
/*
  Self-checking bench of the address filter: register bus master, frame
  rows through the filter, then sticky flags, interrupts and baud ticks.
  Assumes uaf_filter, uaf_node_model and the checker are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none

module uaf_filter_tb;
  typedef struct packed {
    logic [1:0] mode;
    logic mpe;
    logic [7:0] mask;
    logic [9:0] word;
    logic rx_done;
    logic frame_err;
  } uaf_row_type;
  localparam logic [11:0] A_SC = uaf_pkg::UAF_ADDR_SERIAL_CONTROL;
  localparam logic [11:0] A_FC = uaf_pkg::UAF_ADDR_FILTER_CTRL;
  localparam logic [11:0] A_IEN = uaf_pkg::UAF_ADDR_INT_ENABLE;
  localparam logic [11:0] A_ICLR = uaf_pkg::UAF_ADDR_INT_CLEAR;
  localparam logic [11:0] A_IST = uaf_pkg::UAF_ADDR_INT_STATUS;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  uaf_pkg::uaf_rx_frame_type frame;
  uaf_pkg::uaf_baud_src_type baud = 2'h0;
  logic tx_tick, rx_tick, rx_en, irq, send = 1'b0;
  logic [1:0] smode;
  logic [9:0] word = 10'h0;
  logic [31:0] r;
  logic [7:0] sc;
  uaf_row_type rows [11];
  int fails = 0;
  int compares = 0;

  always #50 clk = ~clk;

  uaf_node_model node_u (.clk(clk), .send(send), .word(word), .frame(frame));
  uaf_filter dut_u (.CORE_CLK(clk), .RSTN(rstn), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .RX_FRAME(frame),
    .BAUD_SRC(baud), .TX_BAUD_TICK(tx_tick), .RX_BAUD_TICK(rx_tick),
    .SERIAL_MODE(smode), .RECEIVE_ENABLE(rx_en), .IRQ(irq));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h0);
    check(r, exp);
  endtask

  task automatic send_frame(input logic [9:0] w);
    @(posedge clk);
    send <= 1'b1;
    word <= w;
    @(posedge clk);
    send <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Pulse {timer1, timer2} and look at {tx, rx} while the tick stands
  task automatic tick(input logic [1:0] src, input logic [1:0] exp);
    @(posedge clk);
    baud <= src;
    @(posedge clk);
    baud <= 2'h0;
    #1 check({30'h0, tx_tick, rx_tick}, {30'h0, exp});
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    fails++;
    conclude();
  end

  initial begin
    rows = '{
      '{2'h3, 1'h1, 8'hfc, 10'h357, 1'h1, 1'h0},
      '{2'h3, 1'h1, 8'hfc, 10'h35a, 1'h0, 1'h0},
      '{2'h3, 1'h1, 8'hfc, 10'h3fe, 1'h1, 1'h0},
      '{2'h3, 1'h1, 8'hfc, 10'h156, 1'h0, 1'h0},
      '{2'h3, 1'h0, 8'hfc, 10'h100, 1'h1, 1'h0},
      '{2'h1, 1'h1, 8'hfc, 10'h156, 1'h1, 1'h0},
      '{2'h1, 1'h1, 8'hfc, 10'h056, 1'h0, 1'h1},
      '{2'h1, 1'h1, 8'hfc, 10'h15a, 1'h0, 1'h0},
      '{2'h0, 1'h1, 8'hfc, 10'h05a, 1'h1, 1'h0},
      '{2'h2, 1'h1, 8'hff, 10'h357, 1'h0, 1'h0},
      '{2'h2, 1'h1, 8'hff, 10'h356, 1'h1, 1'h0}};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd_check(uaf_pkg::UAF_ADDR_OWN_ADDRESS, 32'h0);
    rd_check(uaf_pkg::UAF_ADDR_ADDRESS_MASK, 32'h0);
    wr(uaf_pkg::UAF_ADDR_OWN_ADDRESS, 8'h56);
    rd_check(uaf_pkg::UAF_ADDR_OWN_ADDRESS, 32'h56);
    for (int i = 0; i < 11; i++) begin
      sc = {rows[i].mode, rows[i].mpe, 5'h10};
      wr(A_FC, 8'h0);
      wr(A_SC, sc);
      wr(A_FC, 8'h1);
      wr(A_SC, {1'h0, sc[6:0]});
      wr(uaf_pkg::UAF_ADDR_ADDRESS_MASK, rows[i].mask);
      send_frame(rows[i].word);
      bus(1'b0, A_SC, 8'h0);
      check({30'h0, r[7], r[0]}, {30'h0, rows[i].frame_err, rows[i].rx_done});
    end
    // A good frame after a bad one must not clear the error
    wr(A_FC, 8'h0);
    wr(A_SC, 8'h50);
    send_frame(10'h011);
    send_frame(10'h111);
    // Mode 1 keeps the stop bit of the last frame as the marker bit
    rd_check(A_SC, 32'h55);
    wr(A_FC, 8'h1);
    rd_check(A_SC, 32'hd5);
    wr(A_SC, 8'h50);
    rd_check(A_SC, 32'h50);
    wr(A_ICLR, 8'h3);
    wr(A_IEN, 8'h1);
    send_frame(10'h111);
    check({31'h0, irq}, 32'h1);
    rd_check(A_IST, 32'h1);
    wr(A_IEN, 8'h0);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    wr(A_IEN, 8'h1);
    wr(A_ICLR, 8'h1);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rd_check(A_IST, 32'h0);
    rd_check(A_ICLR, 32'h0);
    rd_check(12'hffc, 32'h0);
    check({31'h0, hresp}, 32'h0);
    wr(A_FC, 8'h4);
    tick(2'h2, 2'h1);
    tick(2'h1, 2'h2);
    wr(A_SC, 8'h10);
    tick(2'h3, 2'h0);
    wr(A_SC, 8'hd0);
    check({29'h0, smode, rx_en}, 32'h7);
    wr(A_FC, 8'h0);
    tick(2'h2, 2'h3);
    // Receiver off: a frame must leave every flag alone
    wr(A_SC, 8'h40);
    check({29'h0, smode, rx_en}, 32'h2);
    send_frame(10'h111);
    rd_check(A_SC, 32'h40);
    // Reset in mid-run, held two edges so no check sees the old state
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    check({29'h0, smode, rx_en}, 32'h0);
    rd_check(uaf_pkg::UAF_ADDR_OWN_ADDRESS, 32'h0);
    rd_check(uaf_pkg::UAF_ADDR_ADDRESS_MASK, 32'h0);
    rd_check(A_SC, 32'h0);
    conclude();
  end
endmodule // uaf_filter_tb

`default_nettype wire
